/* File: core/fesc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// host controller that drives the flash through its bus pins
module fesc_host (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic REQ_VALID,
   input wire fesc_pkg::fesc_op_t REQ_OP,
   input wire logic [20:0] REQ_ADDR,
   input wire logic [15:0] REQ_DATA,
   output logic REQ_READY,
   output logic DONE,
   output logic [15:0] RD_DATA,
   output logic ERASE_BUSY,
   output logic ERASE_SUSPENDED,
   output logic PGM_BUSY,
   output logic PGM_SUSPENDED,
   output logic FLASH_CE_N,
   output logic FLASH_WE_N,
   output logic FLASH_OE_N,
   output logic [20:0] FLASH_ADDR,
   output logic [15:0] FLASH_DQ_O,
   output logic FLASH_DQ_OE,
   input wire logic [15:0] FLASH_DQ_I,
   input wire logic FLASH_READY_BUSY_N_OUTPUT_N
);
   import fesc_pkg::*;

   fesc_seq_t seq_q;
   fesc_cyc_t cyc_q;
   fesc_op_t op_q;
   logic [20:0] tgt_q;
   logic [15:0] word_q;
   logic [2:0] idx_q;
   logic [CNT_W-1:0] cnt_q;
   logic rom_wait_q;
   logic is_read_q;
   logic [20:0] rom_addr;
   logic [15:0] rom_data;
   logic [2:0] rom_len;
   logic [1:0] rb_sync_q;
   logic [15:0] dq_meta_q;
   logic [15:0] dq_sync_q;

   // true when the tracked state allows the requested operation
   function automatic logic op_allowed(input fesc_op_t op, input logic eb,
                                       input logic es, input logic pb,
                                       input logic ps);
      case (op)
         OP_SECTOR_ERASE: op_allowed = !eb && !es && !pb && !ps;
         OP_SUSPEND: op_allowed = (eb && !es) || (pb && !ps);
         OP_RESUME: op_allowed = es || ps;
         OP_PROGRAM: op_allowed = !pb && !ps && !(eb && !es);
         default: op_allowed = !(eb && !es) && !(pb && !ps);
      endcase
   endfunction

   fesc_seq_rom u_rom (
      .clk(REF_CLK),
      .op(op_q),
      .idx(idx_q),
      .target(tgt_q),
      .word(word_q),
      .addr_q(rom_addr),
      .data_q(rom_data),
      .len_q(rom_len)
   );

   // ===============================================
   // pin synchronisers; the first stage feeds only the second
   always_ff @(posedge REF_CLK) begin
      rb_sync_q <= {rb_sync_q[0], FLASH_READY_BUSY_N_OUTPUT_N};
      dq_meta_q <= FLASH_DQ_I;
      dq_sync_q <= dq_meta_q;
   end

   // ===============================================
   // sequence control: accept request, issue cycles, finish
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         seq_q <= SQ_IDLE;
         op_q <= OP_READ;
         tgt_q <= 21'h0;
         word_q <= 16'h0;
         idx_q <= 3'h0;
         rom_wait_q <= 1'b0;
         REQ_READY <= 1'b0;
         DONE <= 1'b0;
      end else begin
         DONE <= 1'b0;
         case (seq_q)
            SQ_IDLE: begin
               REQ_READY <= 1'b1;
               if (REQ_VALID && REQ_READY) begin
                  REQ_READY <= 1'b0;
                  // forbidden requests finish at once with no bus cycle
                  if (op_allowed(REQ_OP, ERASE_BUSY, ERASE_SUSPENDED,
                                 PGM_BUSY, PGM_SUSPENDED)) begin
                     op_q <= REQ_OP;
                     tgt_q <= REQ_ADDR;
                     word_q <= REQ_DATA;
                     idx_q <= 3'h0;
                     rom_wait_q <= 1'b1;
                     seq_q <= SQ_ISSUE;
                  end else begin
                     seq_q <= SQ_DONE;
                     // drop the old op so done replays no stale mode change
                     op_q <= OP_READ;
                  end
               end
            end
            SQ_ISSUE: begin
               rom_wait_q <= 1'b0;
               // one clock lets the registered table settle
               if (!rom_wait_q && cyc_q == CY_IDLE) begin
                  seq_q <= SQ_WAIT;
               end
            end
            SQ_WAIT: begin
               if (cyc_q == CY_GAP && cnt_q == CNT_W'(0)) begin
                  if (!is_read_q && idx_q + 3'h1 < rom_len) begin
                     idx_q <= idx_q + 3'h1;
                     rom_wait_q <= 1'b1;
                     seq_q <= SQ_ISSUE;
                  end else begin
                     seq_q <= SQ_DONE;
                  end
               end
            end
            SQ_DONE: begin
               DONE <= 1'b1;
               seq_q <= SQ_IDLE;
            end
            default: seq_q <= SQ_IDLE;
         endcase
      end
   end

   // ===============================================
   // bus cycle engine; ce and we fall together so address is stable
   // before the later falling edge and data holds past the rising one
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         cyc_q <= CY_IDLE;
         cnt_q <= CNT_W'(0);
         is_read_q <= 1'b0;
         FLASH_CE_N <= 1'b1;
         FLASH_WE_N <= 1'b1;
         FLASH_OE_N <= 1'b1;
         FLASH_ADDR <= 21'h0;
         FLASH_DQ_O <= 16'h0;
         FLASH_DQ_OE <= 1'b0;
         RD_DATA <= 16'h0;
      end else begin
         case (cyc_q)
            CY_IDLE: begin
               if (seq_q == SQ_ISSUE && !rom_wait_q) begin
                  is_read_q <= (rom_len == 3'h0);
                  FLASH_ADDR <= rom_addr;
                  FLASH_DQ_O <= rom_data;
                  FLASH_DQ_OE <= (rom_len != 3'h0);
                  cyc_q <= CY_SETUP;
               end
            end
            CY_SETUP: begin
               FLASH_CE_N <= 1'b0;
               FLASH_WE_N <= is_read_q;
               FLASH_OE_N <= !is_read_q;
               cnt_q <= is_read_q ? CNT_W'(READ_CYC) : CNT_W'(WE_LOW_CYC);
               cyc_q <= CY_STROBE;
            end
            CY_STROBE: begin
               if (cnt_q == CNT_W'(1)) begin
                  // data stays driven one clock past the rising edge
                  FLASH_CE_N <= 1'b1;
                  FLASH_WE_N <= 1'b1;
                  FLASH_OE_N <= 1'b1;
                  cyc_q <= CY_HOLD;
               end
               cnt_q <= cnt_q - CNT_W'(1);
            end
            CY_HOLD: begin
               // read data sampled through the synchroniser, two clocks late
               if (is_read_q) begin
                  RD_DATA <= dq_sync_q;
               end
               FLASH_DQ_OE <= 1'b0;
               cnt_q <= CNT_W'(GAP_CYC - 1);
               cyc_q <= CY_GAP;
            end
            CY_GAP: begin
               if (cnt_q == CNT_W'(0)) begin
                  cyc_q <= CY_IDLE;
               end else begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end
            end
            default: cyc_q <= CY_IDLE;
         endcase
      end
   end

   // ===============================================
   // tracked device mode; busy ends when ready/busy rises again
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         ERASE_BUSY <= 1'b0;
         ERASE_SUSPENDED <= 1'b0;
         PGM_BUSY <= 1'b0;
         PGM_SUSPENDED <= 1'b0;
      end else begin
         if (seq_q == SQ_DONE && op_allowed(op_q, ERASE_BUSY,
             ERASE_SUSPENDED, PGM_BUSY, PGM_SUSPENDED) && !DONE) begin
            case (op_q)
               OP_SECTOR_ERASE: ERASE_BUSY <= 1'b1;
               OP_PROGRAM: PGM_BUSY <= 1'b1;
               OP_SUSPEND: begin
                  // program suspend nests inside erase suspend
                  if (PGM_BUSY && !PGM_SUSPENDED) begin
                     PGM_SUSPENDED <= 1'b1;
                  end else begin
                     ERASE_SUSPENDED <= 1'b1;
                  end
               end
               OP_RESUME: begin
                  if (PGM_SUSPENDED) begin
                     PGM_SUSPENDED <= 1'b0;
                  end else begin
                     ERASE_SUSPENDED <= 1'b0;
                  end
               end
               default: ;
            endcase
         end else if (rb_sync_q[1] && seq_q == SQ_IDLE) begin
            // a ready pin means the running operation finished
            if (PGM_BUSY && !PGM_SUSPENDED) begin
               PGM_BUSY <= 1'b0;
            end else if (ERASE_BUSY && !ERASE_SUSPENDED && !PGM_BUSY) begin
               ERASE_BUSY <= 1'b0;
            end
         end
      end
   end

   // an erase sequence starts only when no erase was busy the clock before
   property p_erase_one_at_a_time;
      @(posedge REF_CLK) disable iff (SRST)
      (seq_q == SQ_ISSUE && op_q == OP_SECTOR_ERASE && idx_q == 3'h0)
         |-> !$past(ERASE_BUSY);
   endproperty
   a_erase_one_at_a_time: assert property (p_erase_one_at_a_time)
      else $error("erase started while another was running");

   sequence s_strobe_low;
      !FLASH_WE_N && !FLASH_CE_N;
   endsequence
   property p_data_held;
      @(posedge REF_CLK) disable iff (SRST)
      s_strobe_low ##1 FLASH_WE_N |-> FLASH_DQ_OE;
   endproperty
   a_data_held: assert property (p_data_held)
      else $error("data dropped before write strobe rose");

   // a running erase only ever hears a suspend from us
   property p_erase_only_suspend;
      @(posedge REF_CLK) disable iff (SRST)
      ERASE_BUSY && !ERASE_SUSPENDED && !PGM_BUSY && !FLASH_WE_N
         |-> FLASH_DQ_O == CMD_SUSPEND;
   endproperty
   a_erase_only_suspend: assert property (p_erase_only_suspend)
      else $error("command other than suspend sent during erase");
endmodule
`default_nettype wire

/* File: core/fesc_pkg.sv */
// constants and types shared by the flash command host controller
package fesc_pkg;
   // bus widths of the flash pins
   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   // unlock and command words, low byte only is significant
   localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
   localparam logic [11:0] UNLOCK_ADDR2 = 12'h2aa;
   localparam logic [15:0] UNLOCK_DATA1 = 16'h00aa;
   localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
   localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
   localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
   localparam logic [15:0] CMD_RESUME = 16'h0030;
   localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
   localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
   localparam logic [15:0] CMD_AUTOSELECT = 16'h0090;
   localparam logic [15:0] CMD_RESET = 16'h00f0;
   // lowest address bit that selects a sector
   localparam int SECTOR_LSB = 16;
   // status bit positions on the data pins
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_MAIN_BIT = 6;
   localparam int TOGGLE_ERASE_BIT = 2;
   // bus cycle timing at 40 MHz (25 ns)
   localparam int CLK_NS = 25;
   localparam int WE_LOW_NS = 50;
   localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_NS = 75;
   localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_NS = 25;
   localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
   // suspend latency the device guarantees
   localparam int ERS_SUSP_US = 20;
   localparam int ERS_SUSP_CYC = ERS_SUSP_US * 1000 / CLK_NS;
   localparam int PGM_SUSP_US = 15;
   localparam int PGM_SUSP_CYC = PGM_SUSP_US * 1000 / CLK_NS;
   localparam int CNT_W = 10;
   // host operations requested by the user side
   typedef enum logic [2:0] {
      OP_SECTOR_ERASE = 3'h0,
      OP_SUSPEND = 3'h1,
      OP_RESUME = 3'h2,
      OP_PROGRAM = 3'h3,
      OP_AUTOSELECT = 3'h4,
      OP_RESET = 3'h5,
      OP_READ = 3'h6
   } fesc_op_t;
   // bus cycle engine states
   typedef enum logic [4:0] {
      CY_IDLE = 5'b00001,
      CY_SETUP = 5'b00010,
      CY_STROBE = 5'b00100,
      CY_HOLD = 5'b01000,
      CY_GAP = 5'b10000
   } fesc_cyc_t;
   // whole-sequence states
   typedef enum logic [3:0] {
      SQ_IDLE = 4'b0001,
      SQ_ISSUE = 4'b0010,
      SQ_WAIT = 4'b0100,
      SQ_DONE = 4'b1000
   } fesc_seq_t;
endpackage

/* File: core/fesc_seq_rom.sv */
`timescale 1ns/1ps
`default_nettype none
// registered table of write cycles for each host operation
module fesc_seq_rom (
   input wire logic clk,
   input wire fesc_pkg::fesc_op_t op,
   input wire logic [2:0] idx,
   input wire logic [20:0] target,
   input wire logic [15:0] word,
   output logic [20:0] addr_q,
   output logic [15:0] data_q,
   output logic [2:0] len_q
);
   import fesc_pkg::*;

   // bank/sector bits ride along on every command cycle so banked parts
   // see the right bank; the device ignores them where not needed
   function automatic logic [20:0] cmd_addr(input logic [20:0] t,
                                           input logic [11:0] lo);
      cmd_addr = {t[20:12], lo};
   endfunction

   // ===============================================
   // table lookup, registered
   always_ff @(posedge clk) begin
      addr_q <= cmd_addr(target, UNLOCK_ADDR1);
      data_q <= UNLOCK_DATA1;
      len_q <= 3'h1;
      case (op)
         OP_SECTOR_ERASE: begin
            len_q <= 3'h6;
            case (idx)
               3'h1, 3'h4: begin
                  addr_q <= cmd_addr(target, UNLOCK_ADDR2);
                  data_q <= UNLOCK_DATA2;
               end
               3'h2: data_q <= CMD_ERASE_SETUP;
               3'h5: begin
                  addr_q <= target;
                  data_q <= CMD_SECTOR_ERASE;
               end
               default: data_q <= UNLOCK_DATA1;
            endcase
         end
         OP_PROGRAM, OP_AUTOSELECT: begin
            len_q <= (op == OP_PROGRAM) ? 3'h4 : 3'h3;
            case (idx)
               3'h1: begin
                  addr_q <= cmd_addr(target, UNLOCK_ADDR2);
                  data_q <= UNLOCK_DATA2;
               end
               3'h2: data_q <= (op == OP_PROGRAM) ? CMD_PROGRAM
                                                  : CMD_AUTOSELECT;
               3'h3: begin
                  addr_q <= target;
                  data_q <= word;
               end
               default: data_q <= UNLOCK_DATA1;
            endcase
         end
         OP_SUSPEND: begin
            addr_q <= target;
            data_q <= CMD_SUSPEND;
         end
         OP_RESUME: begin
            addr_q <= target;
            data_q <= CMD_RESUME;
         end
         OP_RESET: data_q <= CMD_RESET;
         default: begin
            addr_q <= target;
            len_q <= 3'h0;
         end
      endcase
   end

   // the setup word sits at the third step of a six-step erase
   property p_erase_words;
      @(posedge clk) op == OP_SECTOR_ERASE && idx == 3'h2
         |=> data_q == CMD_ERASE_SETUP && len_q == 3'h6;
   endproperty
   a_erase_words: assert property (p_erase_words)
      else $error("erase setup word missing from table");

   // suspend is one cycle and must carry the bank address
   property p_suspend_single;
      @(posedge clk) op == OP_SUSPEND
         |=> data_q == CMD_SUSPEND && len_q == 3'h1
            && addr_q == $past(target);
   endproperty
   a_suspend_single: assert property (p_suspend_single)
      else $error("suspend entry is not a single addressed write");
endmodule
`default_nettype wire

/* File: tb/fesc_flash_model.sv */
// behavioural flash device answering the host controller's bus cycles
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// device model
module fesc_flash_model #(
   parameter int ERS_CYC = 400,
   parameter int PGM_CYC = 200,
   parameter int SUS_CYC = 40,
   parameter logic [15:0] ID_CODE = 16'h0a5c // arbitrary value
) (
   input wire logic clk,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [20:0] addr,
   input wire logic [15:0] dq_w,
   output logic [15:0] dq_r,
   output logic ready_busy_n_output,
   output logic [2:0] mode_o,
   output logic [15:0] wr_cnt_o
);
   localparam logic [2:0] RD = 3'h0, ERS = 3'h1, ESU = 3'h2;
   localparam logic [2:0] PGM = 3'h3, PSU = 3'h4;
   logic [15:0] mem [int];
   logic [20:0] wa = '0;
   logic [15:0] wd = '0, rv = '0, pd = '0, wcnt = '0, seen = '0;
   logic [4:0] es = '0, ps = '0;
   logic [2:0] st = '0, md = RD;
   logic auto = 0, in_es = 0, tm = 0, te = 0;
   int ers_left = 0, pgm_left = 0, sus_left = 0;
   wire wr_n = ce_n | we_n;
   wire rd_n = ce_n | oe_n;
   assign mode_o = md;
   assign wr_cnt_o = wcnt;
   // busy only while an embedded job really runs
   assign ready_busy_n_output = !(md == ERS || md == PGM);
   // released bus shows the inverse so a stale value never passes
   assign dq_r = rd_n ? ~rv : rv;

   // address on the later falling edge, data on the earlier rising one
   always @(negedge wr_n) wa = addr;
   always @(posedge wr_n) begin
      wd = dq_w;
      wcnt = wcnt + 16'h0001;
   end

   task automatic do_cmd(input logic [20:0] a, input logic [15:0] w);
      logic [11:0] lo;
      logic [7:0] d;
      int q[$];
      lo = a[11:0];
      d = w[7:0];
      if (md == ERS || md == PGM) begin
         // only a suspend counts while a job runs, address ignored
         if (d == 8'hb0 && sus_left == 0)
            sus_left = SUS_CYC;
         st = 0;
      end else if (st == 6) begin
         mem[int'(a)] = w;
         pd = w;
         ps = a[20:16];
         in_es = (md == ESU);
         md = PGM;
         pgm_left = PGM_CYC;
         st = 0;
      end else if (st == 0 && d == 8'hf0) auto = 0;
      else if (st == 0 && d == 8'h30 && md == ESU && a[20:16] == es)
         md = ERS;
      else if (st == 0 && d == 8'h30 && md == PSU) md = PGM;
      else if (st == 0 || st == 3)
         st = (lo == 12'h555 && d == 8'haa) ? st + 3'h1 : 3'h0;
      else if (st == 1 || st == 4)
         st = (lo == 12'h2aa && d == 8'h55) ? st + 3'h1 : 3'h0;
      else if (st == 2) begin
         if (lo != 12'h555) st = 3'h0;
         else if (d == 8'h80) st = 3'h3;
         else if (d == 8'ha0) st = 3'h6;
         else st = 3'h0;
         if (lo == 12'h555 && d == 8'h90) auto = 1;
      end else begin
         // sector picked by the top address bits
         if (d == 8'h30 && md == RD) begin
            es = a[20:16];
            md = ERS;
            ers_left = ERS_CYC;
            foreach (mem[k]) if (k[20:16] == es) q.push_back(k);
            foreach (q[i]) mem.delete(q[i]);
         end
         st = 0;
      end
   endtask

   // decode one finished write per clock, then run the job timers
   always @(posedge clk) begin
      if (seen != wcnt) begin
         seen = wcnt;
         if (^{wa, wd} !== 1'bx) do_cmd(wa, wd);
      end
      if (sus_left > 0) begin
         sus_left--;
         if (sus_left == 0) md = (md == ERS) ? ESU : PSU;
      end else if (md == ERS) begin
         ers_left--;
         if (ers_left == 0) md = RD;
      end else if (md == PGM) begin
         pgm_left--;
         if (pgm_left == 0) begin
            md = in_es ? ESU : RD;
            in_es = 0;
         end
      end
   end

   // ID code while autoselect is on, else status everywhere while a job runs, inside suspended sectors when suspended, array data elsewhere
   always @(negedge rd_n) begin
      if (auto) rv = ID_CODE;
      else if (md == ERS) begin
         tm = ~tm;
         te = ~te;
         rv = {8'h00, 1'b0, tm, 3'b000, te, 2'b00};
      end else if (md == PGM) begin
         tm = ~tm;
         rv = {8'h00, ~pd[7], tm, 6'h00};
      end else if (md != RD && addr[20:16] == es && (md == ESU || in_es)) begin
         te = ~te;
         rv = {8'h00, 1'b1, tm, 3'b000, te, 2'b00};
      end else if (md == PSU && addr[20:16] == ps)
         rv = {8'h00, ~pd[7], tm, 6'h00};
      else
         rv = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hffff;
   end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the flash command host controller
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench top
module tb_top;
   import fesc_pkg::*;
   logic clk, srst, valid, ready, done, eb, esp, pb, psp;
   logic ce_n, we_n, oe_n, dq_oe, rb_n;
   fesc_op_t op;
   logic [20:0] ra, fa;
   logic [15:0] rd, rdata, dq_o, dq_i, dq_r, wcnt, w0, r1;
   logic [2:0] mode;
   int bad_count = 0, n_compared = 0;
   // wire level: whoever enables drives the data lines
   assign dq_i = dq_oe ? dq_o : dq_r;

   fesc_host i_fesc_host (
      .REF_CLK(clk), .SRST(srst), .REQ_VALID(valid), .REQ_OP(op),
      .REQ_ADDR(ra), .REQ_DATA(rd), .REQ_READY(ready), .DONE(done),
      .RD_DATA(rdata), .ERASE_BUSY(eb), .ERASE_SUSPENDED(esp),
      .PGM_BUSY(pb), .PGM_SUSPENDED(psp), .FLASH_CE_N(ce_n),
      .FLASH_WE_N(we_n), .FLASH_OE_N(oe_n), .FLASH_ADDR(fa),
      .FLASH_DQ_O(dq_o), .FLASH_DQ_OE(dq_oe), .FLASH_DQ_I(dq_i),
      .FLASH_READY_BUSY_N_OUTPUT_N(rb_n));
   fesc_flash_model i_fesc_flash_model (
      .clk(clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(fa),
      .dq_w(dq_o), .dq_r(dq_r), .ready_busy_n_output(rb_n),
      .mode_o(mode), .wr_cnt_o(wcnt));

   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one request offered for a single clock once ready, then a bounded wait for done
   task automatic req(input fesc_op_t o, input logic [20:0] a,
                      input logic [15:0] d);
      for (int n = 0; n < 100 && ready !== 1'b1; n++) @(posedge clk) #1;
      valid = 1;
      op = o;
      ra = a;
      rd = d;
      @(posedge clk) #1;
      valid = 0;
      for (int n = 0; n < 200 && done !== 1'b1; n++) @(posedge clk) #1;
      chk(16'(done), 16'h0001);
   endtask

   // device mode reached within the bound, sync flops given time
   task automatic wait_mode(input logic [2:0] m);
      // suspend latency limits bound how long a mode change may take
      int lim = (m == 3'h4) ? PGM_SUSP_CYC : ERS_SUSP_CYC;
      for (int n = 0; n < lim && mode !== m; n++) @(posedge clk) #1;
      repeat (4) @(posedge clk);
      #1;
      chk(16'(mode), 16'(m));
   endtask

   task automatic idle();
      for (int n = 0; n < 2000 && {eb, pb} !== 2'b00; n++) @(posedge clk) #1;
      chk(16'({eb, pb}), 16'h0000);
   endtask

   task automatic t_erase();
      req(OP_PROGRAM, 21'h020010, 16'h1234);
      idle();
      w0 = wcnt;
      // nothing runs, so a suspend is refused and must leave no stale state
      req(OP_SUSPEND, 21'h020000, 16'h0000);
      chk(16'({eb, pb}), 16'h0000);
      req(OP_SECTOR_ERASE, 21'h020000, 16'h0000);
      chk(wcnt - w0, 16'h0006);
      chk(16'({eb, pb}), 16'h0002);
      w0 = wcnt;
      req(OP_PROGRAM, 21'h040000, 16'h0001);
      req(OP_SECTOR_ERASE, 21'h040000, 16'h0000);
      chk(wcnt, w0);
      idle();
      chk(16'(mode), 16'h0000);
      req(OP_READ, 21'h020010, 16'h0000);
      chk(rdata, 16'hffff);
   endtask

   task automatic t_suspend();
      req(OP_SECTOR_ERASE, 21'h030000, 16'h0000);
      req(OP_SUSPEND, 21'h030000, 16'h0000);
      wait_mode(3'h2);
      chk(16'(esp), 16'h0001);
      req(OP_READ, 21'h030020, 16'h0000);
      r1 = rdata;
      req(OP_READ, 21'h030020, 16'h0000);
      chk(16'(r1[7]), 16'h0001);
      chk(16'({r1[6] ^ rdata[6], r1[2] ^ rdata[2]}), 16'h0001);
      req(OP_PROGRAM, 21'h050004, 16'h00c3);
      wait_mode(3'h2);
      chk(16'({pb, esp}), 16'h0001);
      req(OP_READ, 21'h050004, 16'h0000);
      chk(rdata, 16'h00c3);
      req(OP_AUTOSELECT, 21'h050000, 16'h0000);
      req(OP_READ, 21'h050000, 16'h0000);
      chk(rdata, 16'h0a5c);
      req(OP_RESET, 21'h000000, 16'h0000);
      req(OP_READ, 21'h050004, 16'h0000);
      chk(rdata, 16'h00c3);
      req(OP_RESUME, 21'h030000, 16'h0000);
      wait_mode(3'h1);
      w0 = wcnt;
      req(OP_RESUME, 21'h030000, 16'h0000);
      chk(wcnt, w0);
      req(OP_SUSPEND, 21'h030000, 16'h0000);
      wait_mode(3'h2);
      req(OP_RESUME, 21'h030000, 16'h0000);
      idle();
      req(OP_READ, 21'h030020, 16'h0000);
      chk(rdata, 16'hffff);
   endtask

   task automatic t_pgm_suspend();
      req(OP_PROGRAM, 21'h060008, 16'h5a5a);
      req(OP_SUSPEND, 21'h1fffff, 16'h0000);
      wait_mode(3'h4);
      chk(16'(psp), 16'h0001);
      req(OP_READ, 21'h050004, 16'h0000);
      chk(rdata, 16'h00c3);
      req(OP_AUTOSELECT, 21'h060000, 16'h0000);
      req(OP_READ, 21'h060008, 16'h0000);
      chk(rdata, 16'h0a5c);
      req(OP_RESET, 21'h000000, 16'h0000);
      chk(16'(mode), 16'h0004);
      req(OP_RESUME, 21'h000000, 16'h0000);
      wait_mode(3'h3);
      idle();
      req(OP_READ, 21'h060008, 16'h0000);
      chk(rdata, 16'h5a5a);
   endtask

   task automatic give_verdict();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // a hang is cut short well past the expected run length
   initial begin
      #(25 * 30000);
      bad_count++;
      give_verdict();
   end

   initial begin
      srst = 1;
      valid = 0;
      op = OP_READ;
      ra = '0;
      rd = '0;
      repeat (5) @(posedge clk);
      #1 srst = 0;
      t_erase();
      t_suspend();
      t_pgm_suspend();
      give_verdict();
   end
endmodule
`default_nettype wire
